// *** verilog/tda_trigger_delay_adjust.sv ***
// Purpose: hub-wide trigger delay adjust on the distributed sample clock
// Assumes: distClk runs free while the hub is in a distributed mode
// Notes: one adjust register serves every card on the hub
//
// Chosen here: the Wishbone register port.
`timescale 1ns/1ps

module tda_trigger_delay_adjust
(
  // core clock and reset
  input wire logic coreClk,
  input wire logic srst,
  // wishbone slave
  input wire tda_pkg::tda_wb_req_t wbReq,
  output logic wbAck,
  output logic [31:0] wbDatO,
  // distribution link
  input wire logic distClk,
  input wire logic distTrigIn,
  // local trigger source and hub-wide trigger out (distClk domain)
  input wire logic localTrig,
  output logic hubTrig
);

  ////////////////////////////////////////////////////////////////////////////
  // core domain: register file

  tda_pkg::tda_core_t coreReg;
  tda_pkg::tda_core_t coreNext;
  logic [2:0] seenSync;
  logic [1:0] lastSync;
  logic [2:0] rstHold;
  logic linkRstReq;
  logic [1:0] linkRst;

  // stretch reset so the slower link clock sees it for several edges;
  // a two-cycle srst alone could fall between two link edges
  always_ff @(posedge coreClk)
  begin
    if (srst)
    begin
      rstHold <= 3'h7;
      linkRstReq <= 1'b1;
    end
    else
    begin
      rstHold <= rstHold == 3'h0 ? 3'h0 : 3'(rstHold - 3'h1);
      linkRstReq <= rstHold != 3'h0;
    end
  end

  // bus decode; ack drops the cycle after it was given
  always_comb
  begin
    coreNext = coreReg;
    coreNext.ack = 1'b0;
    if (seenSync[2] != seenSync[1])
    begin
      coreNext.seen = 1'b1;
    end
    if (wbReq.cyc && wbReq.stb && !coreReg.ack)
    begin
      coreNext.ack = 1'b1;
      coreNext.rdat = 32'h0;
      if (wbReq.adr == tda_pkg::ADJ_OFFSET)
      begin
        coreNext.rdat = {29'h0, coreReg.adj};
        // out-of-range values are dropped, keeping the last good one
        if (wbReq.we && wbReq.sel[0] && wbReq.dat[31:3] == 29'h0
            && wbReq.dat[2:0] >= tda_pkg::ADJ_MIN && wbReq.dat[2:0] <= tda_pkg::ADJ_MAX)
        begin
          coreNext.adj = wbReq.dat[2:0];
        end
      end
      else if (wbReq.adr == tda_pkg::MODE_OFFSET)
      begin
        coreNext.rdat = {28'h0, coreReg.mode};
        if (wbReq.we && wbReq.sel[0] && wbReq.dat[31:4] == 28'h0
            && (wbReq.dat[3:0] == tda_pkg::MODE_STANDARD
            || wbReq.dat[3:0] == tda_pkg::MODE_CLOCK_ONLY
            || wbReq.dat[3:0] == tda_pkg::MODE_RISING
            || wbReq.dat[3:0] == tda_pkg::MODE_FALLING))
        begin
          coreNext.mode = wbReq.dat[3:0];
        end
      end
      else if (wbReq.adr == tda_pkg::STATUS_OFFSET)
      begin
        coreNext.rdat[tda_pkg::STAT_SEEN_BIT] = coreReg.seen;
        coreNext.rdat[tda_pkg::STAT_LAST_BIT] = lastSync[1];
        // write-one clears the seen flag; a new event in the same cycle wins
        if (wbReq.we && wbReq.sel[0] && wbReq.dat[tda_pkg::STAT_SEEN_BIT]
            && seenSync[2] == seenSync[1])
        begin
          coreNext.seen = 1'b0;
        end
      end
    end
  end

  // core register; adj and mode reset to their defaults
  always_ff @(posedge coreClk)
  begin
    if (srst)
    begin
      coreReg <= '{ack: 1'b0, rdat: 32'h0, adj: tda_pkg::ADJ_RESET,
                   mode: tda_pkg::MODE_RESET, seen: 1'b0};
    end
    else
    begin
      coreReg <= coreNext;
    end
  end

  assign wbAck = coreReg.ack;
  assign wbDatO = coreReg.rdat;

  ////////////////////////////////////////////////////////////////////////////
  // link domain: capture and delay

  tda_pkg::tda_link_t linkReg;
  tda_pkg::tda_link_t linkNext;
  logic trigFallReg;
  logic [1:0] adjSel;
  logic [1:0] modeSel;

  // adj and mode are quasi-static levels; each encoded to two bits and
  // synchronised per bit, so software must change them only while idle
  always_comb
  begin
    adjSel = coreReg.adj == 3'h2 ? 2'h2 : (coreReg.adj == 3'h3 ? 2'h1 : 2'h0);
    case (coreReg.mode)
      tda_pkg::MODE_RISING: modeSel = 2'h1;
      tda_pkg::MODE_FALLING: modeSel = 2'h2;
      tda_pkg::MODE_CLOCK_ONLY: modeSel = 2'h3;
      default: modeSel = 2'h0;
    endcase
  end

  // falling-edge capture avoids races at some sample rates
  always_ff @(negedge distClk)
  begin
    trigFallReg <= distTrigIn;
  end

  always_comb
  begin
    linkNext = linkReg;
    linkNext.adjSync0 = adjSel;
    linkNext.adjSync1 = linkReg.adjSync0;
    linkNext.modeSync0 = modeSel;
    linkNext.modeSync1 = linkReg.modeSync0;
    // a late trigger simply lands one edge later: whole-sample shift
    linkNext.trigRise = distTrigIn;
    linkNext.trigFall = trigFallReg;
    // chain stage 0 is the captured sample; total lag is 5 at default
    linkNext.chain = {linkReg.chain[2:0],
                      linkReg.modeSync1 == 2'h2 ? linkReg.trigFall : linkReg.trigRise};
    case (linkReg.modeSync1)
      2'h1, 2'h2: linkNext.trigOut = linkReg.chain[tda_pkg::CHAIN_LEN - 2
                                     - linkReg.adjSync1];
      default: linkNext.trigOut = localTrig;
    endcase
    if (linkNext.trigOut && !linkReg.trigOut)
    begin
      linkNext.toggle = !linkReg.toggle;
    end
  end

  // link state is cleared by the synchronised, stretched core reset;
  // without it the event toggle would stay unknown for ever
  always_ff @(posedge distClk)
  begin
    linkRst <= {linkRst[0], linkRstReq};
    if (linkRst[1])
    begin
      linkReg <= '0;
    end
    else
    begin
      linkReg <= linkNext;
    end
  end

  assign hubTrig = linkReg.trigOut;

  // event toggle and last level back into the core domain
  always_ff @(posedge coreClk)
  begin
    if (srst)
    begin
      seenSync <= 3'h0;
      lastSync <= 2'h0;
    end
    else
    begin
      seenSync <= {seenSync[1:0], linkReg.toggle};
      lastSync <= {lastSync[0], linkReg.trigOut};
    end
  end

endmodule : tda_trigger_delay_adjust

// *** verilog/tda_pkg.sv ***
// Purpose: constants and carrier types for the trigger delay adjust block
// Assumes: classic wishbone, 32-bit data, byte addresses
// Notes: sync mode codes mirror the hub's mode encoding
package tda_pkg;

  // register map
  localparam logic [15:0] ADJ_OFFSET = 16'hc058;
  localparam logic [15:0] MODE_OFFSET = 16'hc05c;
  localparam logic [15:0] STATUS_OFFSET = 16'hc060;

  // adjustment values
  localparam logic [2:0] ADJ_RESET = 3'h4;
  localparam logic [2:0] ADJ_MAX = 3'h4;
  localparam logic [2:0] ADJ_MIN = 3'h2;

  // synchronization mode codes
  localparam logic [3:0] MODE_STANDARD = 4'h1;
  localparam logic [3:0] MODE_CLOCK_ONLY = 4'h2;
  localparam logic [3:0] MODE_RISING = 4'h4;
  localparam logic [3:0] MODE_FALLING = 4'h8;
  localparam logic [3:0] MODE_RESET = 4'h1;

  // shift chain depth and status fields
  localparam int CHAIN_LEN = 4;
  localparam int STAT_SEEN_BIT = 0;
  localparam int STAT_LAST_BIT = 1;

  // wishbone request bundle
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [15:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } tda_wb_req_t;

  // core-domain state
  typedef struct packed {
    logic ack;
    logic [31:0] rdat;
    logic [2:0] adj;
    logic [3:0] mode;
    logic seen;
  } tda_core_t;

  // link-domain state
  typedef struct packed {
    logic [1:0] adjSync0;
    logic [1:0] adjSync1;
    logic [1:0] modeSync0;
    logic [1:0] modeSync1;
    logic trigRise;
    logic trigFall;
    logic [3:0] chain;
    logic trigOut;
    logic toggle;
  } tda_link_t;

endpackage : tda_pkg

// *** tb/tda_dist_card.sv ***
// Purpose: distribution card model
// Assumes: returned clock runs free
// Notes: trigger launched just after a rising edge
`timescale 1ns/1ps
module tda_dist_card
(
  // bench control
  input wire logic fire,
  // returned clock and trigger
  output logic distClk = 1'b0,
  output logic distTrigIn = 1'b0
);
  // 8 MHz, phase unrelated to core clock
  always #62.5 distClk = ~distClk;
  // launch late so either edge samples a settled level
  always @(posedge distClk)
    distTrigIn <= fire;
endmodule : tda_dist_card

// *** tb/tda_checker_props.sv ***
// Purpose: bus checks at the top ports
// Assumes: master holds request until ack
// Notes: link timing is judged by the bench
`timescale 1ns/1ps
module tda_checker
(
  // core side
  input wire logic coreClk,
  input wire logic srst,
  input wire tda_pkg::tda_wb_req_t wbReq,
  input wire logic wbAck,
  input wire logic [31:0] wbDatO
);
  default clocking cb @(posedge coreClk); endclocking
  default disable iff (srst);
  logic req;
  logic rdAck;
  logic [15:0] adr;
  logic adjWr;
  assign req = wbReq.cyc & wbReq.stb;
  assign rdAck = wbAck & ~wbReq.we;
  assign adr = wbReq.adr;
  // any write to the adjust register, legal or not, ends the default window
  always_ff @(posedge coreClk)
    if (srst)
      adjWr <= 1'b0;
    else if (wbAck && wbReq.we && adr == 16'hc058)
      adjWr <= 1'b1;
  a_ack_next: assert property (req && !wbAck |=> wbAck)
    else $error("late ack");
  a_ack_pulse: assert property (wbAck |=> !wbAck)
    else $error("long ack");
  a_no_stray: assert property (!req |=> !wbAck)
    else $error("stray ack");
  a_adj_default: assert property (rdAck && adr == 16'hc058 && !adjWr |-> wbDatO == 32'h4)
    else $error("bad default");
  a_adj_legal: assert property (rdAck && adr == 16'hc058 |-> wbDatO inside {2, 3, 4})
    else $error("bad adjust");
  a_mode_legal: assert property (rdAck && adr == 16'hc05c |-> wbDatO inside {1, 2, 4, 8})
    else $error("bad mode");
  a_stat_upper: assert property (rdAck && adr == 16'hc060 |-> wbDatO[31:2] == 30'h0)
    else $error("bad status");
  a_unmapped_zero: assert property (rdAck && !(adr inside {16'hc058, 16'hc05c, 16'hc060})
    |-> wbDatO == 32'h0)
    else $error("unmapped data");
endmodule : tda_checker
bind tda_trigger_delay_adjust tda_checker i_tda_checker (.coreClk, .srst, .wbReq, .wbAck,
  .wbDatO);

// *** tb/tb.sv ***
// Purpose: bench for trigger delay adjust
// Assumes: ack one cycle after request
// Notes: latency counted in distClk edges
`timescale 1ns/1ps
module tb;
  logic coreClk = 1'b0;
  logic srst = 1'b1;
  tda_pkg::tda_wb_req_t wbReq = '0;
  logic wbAck;
  logic [31:0] wbDatO;
  logic distClk;
  logic distTrigIn;
  logic localTrig = 1'b0;
  logic hubTrig;
  logic fire = 1'b0;
  logic [31:0] rdat;
  int mismatches = 0;
  int samplesChecked = 0;
  int n;
  always #25 coreClk = ~coreClk;
  tda_trigger_delay_adjust i_tda_trigger_delay_adjust (.coreClk, .srst, .wbReq, .wbAck,
    .wbDatO, .distClk, .distTrigIn, .localTrig, .hubTrig);
  tda_dist_card i_tda_dist_card (.fire, .distClk, .distTrigIn);
  task automatic stop_test();
    $display("mismatches %0d checked %0d", mismatches, samplesChecked);
    if (mismatches == 0 && samplesChecked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : stop_test
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samplesChecked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask : check
  // held until ack is sampled, then one idle cycle
  task automatic bus(input logic we, input logic [15:0] adr, input logic [31:0] dat);
    int i;
    wbReq <= '{1'b1, 1'b1, we, adr, 4'hf, dat};
    for (i = 0; i < 20 && wbAck !== 1'b1; i++)
      @(posedge coreClk);
    check(32'(i < 20), 32'h1);
    if (i >= 20)
      stop_test();
    rdat = wbDatO;
    wbReq <= '0;
    @(posedge coreClk);
  endtask : bus
  task automatic rd(input logic [15:0] adr, input logic [31:0] exp);
    bus(1'b0, adr, 32'h0);
    check(rdat, exp);
  endtask : rd
  // wait lets the setting cross first; the tail lets the chain drain
  task automatic lat(input logic loc, output int cnt);
    repeat (4) @(posedge distClk);
    fire <= ~loc;
    localTrig <= loc;
    for (cnt = 0; cnt < 20 && hubTrig !== 1'b1; cnt++)
    begin
      @(posedge distClk);
      #1;
    end
    fire <= 1'b0;
    localTrig <= 1'b0;
    repeat (12) @(posedge distClk);
  endtask : lat
  initial
  begin
    repeat (2) @(posedge coreClk);
    srst <= 1'b0;
    @(posedge coreClk);
    rd(16'hc058, 32'h4);
    rd(16'hc05c, 32'h1);
    rd(16'hc064, 32'h0);
    bus(1'b1, 16'hc058, 32'h5);
    rd(16'hc058, 32'h4);
    for (int m = 0; m < 2; m++)
      for (int a = 4; a >= 2; a--)
      begin
        bus(1'b1, 16'hc05c, m ? 32'h8 : 32'h4);
        bus(1'b1, 16'hc058, 32'(a));
        rd(16'hc058, 32'(a));
        lat(1'b0, n);
        check(32'(n), 32'(a + 2));
      end
    rd(16'hc060, 32'h1);
    bus(1'b1, 16'hc060, 32'h1);
    rd(16'hc060, 32'h0);
    for (int m = 1; m <= 2; m++)
    begin
      bus(1'b1, 16'hc05c, 32'(m));
      lat(1'b1, n);
      check(32'(n), 32'h1);
    end
    stop_test();
  end
endmodule : tb
